// [hw/alu_decode_pkg.sv]
/*
 Package for the arithmetic/logic opcode decoder: operation codes,
 operand sources, register select codes and cycle counts.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package alu_decode_pkg;
   typedef enum logic [4:0] {
      op_none, op_add, op_add_carry, op_pair_add, op_sub, op_sub_borrow,
      op_and, op_xor, op_or, op_compare,
      op_rotate_left, op_rotate_right, op_rotate_left_thru_carry,
      op_rotate_right_thru_carry,
      op_acc_invert, op_carry_set, op_carry_invert, op_decimal_adjust,
      op_irq_enable, op_irq_disable, op_no_operation, op_stop,
      op_mask_read, op_mask_write
   } alu_op_e;

   typedef enum logic [1:0] {
      src_none, src_reg, src_mem, src_imm
   } operand_src_e;

   localparam logic [2:0] REG_B = 3'h0;
   localparam logic [2:0] REG_C = 3'h1;
   localparam logic [2:0] REG_D = 3'h2;
   localparam logic [2:0] REG_E = 3'h3;
   localparam logic [2:0] REG_H = 3'h4;
   localparam logic [2:0] REG_L = 3'h5;
   localparam logic [2:0] REG_MEM = 3'h6;
   localparam logic [2:0] REG_ACC = 3'h7;

   localparam logic [1:0] PAIR_BC = 2'h0;
   localparam logic [1:0] PAIR_DE = 2'h1;
   localparam logic [1:0] PAIR_HL = 2'h2;
   localparam logic [1:0] PAIR_SP = 2'h3;

   localparam int SEL_LSB = 0;
   localparam int GROUP_LSB = 3;
   localparam int PAIR_LSB = 4;

   localparam logic [4:0] CYC_NONE = 5'h00;
   localparam logic [4:0] CYC_REG = 5'h04;
   localparam logic [4:0] CYC_MEM = 5'h07;
   localparam logic [4:0] CYC_PAIR = 5'h0a;
   localparam logic [4:0] CYC_STOP = 5'h05;

   localparam logic [7:0] OPC_ADD_MEM = 8'h86;
   localparam logic [7:0] OPC_ADC_MEM = 8'h8e;
   localparam logic [7:0] OPC_ADD_IMM = 8'hc6;
   localparam logic [7:0] OPC_ADC_IMM = 8'hce;
   localparam logic [7:0] OPC_SUB_IMM = 8'hd6;
   localparam logic [7:0] OPC_SUB_BORROW_IMM = 8'hde;
   localparam logic [7:0] OPC_AND_IMM = 8'he6;
   localparam logic [7:0] OPC_XOR_IMM = 8'hee;
   localparam logic [7:0] OPC_OR_IMM = 8'hf6;
   localparam logic [7:0] OPC_COMPARE_IMM = 8'hfe;
   localparam logic [7:0] OPC_ROTATE_LEFT = 8'h07;
   localparam logic [7:0] OPC_ROTATE_RIGHT = 8'h0f;
   localparam logic [7:0] OPC_ROTATE_LEFT_CARRY = 8'h17;
   localparam logic [7:0] OPC_ROTATE_RIGHT_CARRY = 8'h1f;
   localparam logic [7:0] OPC_DECIMAL_ADJUST = 8'h27;
   localparam logic [7:0] OPC_ACC_INVERT = 8'h2f;
   localparam logic [7:0] OPC_CARRY_SET = 8'h37;
   localparam logic [7:0] OPC_CARRY_INVERT = 8'h3f;
   localparam logic [7:0] OPC_IRQ_ENABLE = 8'hfb;
   localparam logic [7:0] OPC_IRQ_DISABLE = 8'hf3;
   localparam logic [7:0] OPC_NO_OPERATION = 8'h00;
   localparam logic [7:0] OPC_MASK_READ = 8'h20;
   localparam logic [7:0] OPC_MASK_WRITE = 8'h30;
   localparam logic [7:0] OPC_STOP = 8'h76;
endpackage
`default_nettype wire

// [hw/cpu8_arith_logic_decode.sv]
/*
 Registered decoder for arithmetic, logical, rotate, special and control
 opcodes of an 8-bit processor. One opcode per strobe; results appear one
 clock later; decoded_o pulses once per strobe, the other outputs hold until the next strobe.
 Assumes opcode bytes arrive synchronous to clk_sys_i with a one-cycle
 valid strobe; condition flags are evaluated elsewhere.

// Functional notes
// - Select field codes B..L as 000..101, memory via H&L 110, accumulator 111.
// - 86h adds memory byte, 8Eh adds memory with carry; seven cycles.
// - C6h adds immediate byte, CEh adds immediate with carry; seven cycles.
// - 00pp1001 adds pair BC/DE/HL/SP to H&L in ten cycles.
// - 10010 plus source field subtracts register, 10011 with borrow; four cycles.
// - 96h and 9Eh subtract memory byte, plain and with borrow; seven cycles.
// - D6h and DEh subtract immediate byte, plain and with borrow; seven cycles.
// - Register AND/XOR/OR/compare are 10100..10111 plus source field; four cycles.
// - Memory AND/XOR/OR/compare at A6h/AEh/B6h/BEh, seven cycles.
// - Immediate AND/XOR/OR/compare at E6h/EEh/F6h/FEh, seven cycles.
// - Rotates left 07h, right 0Fh, through carry 17h and 1Fh; four cycles.
*/
`default_nettype none
module cpu8_arith_logic_decode
   import alu_decode_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic opcode_valid_i,
   input wire logic [7:0] opcode_i,
   output logic decoded_o,
   output logic hit_o,
   output alu_op_e op_o,
   output operand_src_e src_o,
   output logic [2:0] src_reg_field_o,
   output logic [1:0] pair_o,
   output logic [4:0] cycles_o
);
   logic rst_meta_r;
   logic rst_sync_r;

   // Two flops, so that a release close to the clock edge cannot leave part
   // of the decode registers in reset and part of them running
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Group bits 5:3 of an ALU opcode into an operation
   function automatic alu_op_e alu_group(input logic [7:0] opc);
      alu_op_e r;
      r = op_none;
      unique case (opc[GROUP_LSB +: 3])
         3'h0: r = op_add;
         3'h1: r = op_add_carry;
         3'h2: r = op_sub;
         3'h3: r = op_sub_borrow;
         3'h4: r = op_and;
         3'h5: r = op_xor;
         3'h6: r = op_or;
         3'h7: r = op_compare;
      endcase
      return r;
   endfunction

   // Select field 110 names the byte at H&L rather than a register
   function automatic logic sel_is_mem(input logic [7:0] opc);
      return opc[SEL_LSB +: 3] == REG_MEM;
   endfunction

   // Register and memory ALU block: 10, group, select
   function automatic logic is_alu_reg_block(input logic [7:0] opc);
      return opc[7:6] == 2'b10;
   endfunction

   // Immediate ALU block: 11, group, 110; the operand is the next byte
   function automatic logic is_alu_imm(input logic [7:0] opc);
      return opc[7:6] == 2'b11 && sel_is_mem(opc);
   endfunction

   // Pair add: 00, pair, 1001
   function automatic logic is_pair_add(input logic [7:0] opc);
      return opc[7:6] == 2'b00 && opc[3:0] == 4'h9;
   endfunction

   logic decoded_r;
   logic decoded_nxt;

   // Pulse group: one cycle per taken opcode, dropped while reset settles
   always_comb begin
      decoded_nxt = 1'b0;
      if (rst_sync_r) begin
         decoded_nxt = opcode_valid_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         decoded_r <= 1'b0;
      end else begin
         decoded_r <= decoded_nxt;
      end
   end

   logic hit_r;
   logic hit_nxt;
   alu_op_e op_r;
   alu_op_e op_nxt;
   operand_src_e src_r;
   operand_src_e src_nxt;
   logic [2:0] sel_r;
   logic [2:0] sel_nxt;
   logic [1:0] pair_r;
   logic [1:0] pair_nxt;
   logic [4:0] cyc_r;
   logic [4:0] cyc_nxt;

   // Decode group: fields hold between strobes so the sequencer may read
   // them late; the cost is one register per field instead of plain gates
   always_comb begin
      hit_nxt = hit_r;
      op_nxt = op_r;
      src_nxt = src_r;
      sel_nxt = sel_r;
      pair_nxt = pair_r;
      cyc_nxt = cyc_r;
      if (!rst_sync_r) begin
         // Strobes before the release has settled are dropped
         hit_nxt = 1'b0;
         op_nxt = op_none;
         src_nxt = src_none;
         sel_nxt = REG_B;
         pair_nxt = PAIR_BC;
         cyc_nxt = CYC_NONE;
      end else if (opcode_valid_i) begin
         hit_nxt = 1'b1;
         op_nxt = op_none;
         src_nxt = src_none;
         sel_nxt = opcode_i[SEL_LSB +: 3];
         pair_nxt = opcode_i[PAIR_LSB +: 2];
         cyc_nxt = CYC_REG;
         if (is_alu_reg_block(opcode_i)) begin
            op_nxt = alu_group(opcode_i);
            if (sel_is_mem(opcode_i)) begin
               src_nxt = src_mem;
               cyc_nxt = CYC_MEM;
            end else begin
               src_nxt = src_reg;
               cyc_nxt = CYC_REG;
            end
         end else if (is_alu_imm(opcode_i)) begin
            // The operand byte is fetched elsewhere; it is only flagged here
            op_nxt = alu_group(opcode_i);
            src_nxt = src_imm;
            cyc_nxt = CYC_MEM;
         end else if (is_pair_add(opcode_i)) begin
            op_nxt = op_pair_add;
            cyc_nxt = CYC_PAIR;
         end else begin
            unique case (opcode_i)
               OPC_ROTATE_LEFT: op_nxt = op_rotate_left;
               OPC_ROTATE_RIGHT: op_nxt = op_rotate_right;
               OPC_ROTATE_LEFT_CARRY: op_nxt = op_rotate_left_thru_carry;
               OPC_ROTATE_RIGHT_CARRY: op_nxt = op_rotate_right_thru_carry;
               OPC_ACC_INVERT: op_nxt = op_acc_invert;
               OPC_CARRY_SET: op_nxt = op_carry_set;
               OPC_CARRY_INVERT: op_nxt = op_carry_invert;
               OPC_DECIMAL_ADJUST: op_nxt = op_decimal_adjust;
               OPC_IRQ_ENABLE: op_nxt = op_irq_enable;
               OPC_IRQ_DISABLE: op_nxt = op_irq_disable;
               OPC_NO_OPERATION: op_nxt = op_no_operation;
               OPC_MASK_READ: op_nxt = op_mask_read;
               OPC_MASK_WRITE: op_nxt = op_mask_write;
               OPC_STOP: begin
                  op_nxt = op_stop;
                  cyc_nxt = CYC_STOP;
               end
               default: begin
                  // Jumps, calls, returns and moves belong to other decoders;
                  // their flag-dependent paired counts are resolved there
                  hit_nxt = 1'b0;
                  cyc_nxt = CYC_NONE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hit_r <= 1'b0;
         op_r <= op_none;
         src_r <= src_none;
         sel_r <= REG_B;
         pair_r <= PAIR_BC;
         cyc_r <= CYC_NONE;
      end else begin
         hit_r <= hit_nxt;
         op_r <= op_nxt;
         src_r <= src_nxt;
         sel_r <= sel_nxt;
         pair_r <= pair_nxt;
         cyc_r <= cyc_nxt;
      end
   end

   assign decoded_o = decoded_r;
   assign hit_o = hit_r;
   assign op_o = op_r;
   assign src_o = src_r;
   assign src_reg_field_o = sel_r;
   assign pair_o = pair_r;
   assign cycles_o = cyc_r;
endmodule
`default_nettype wire

// [sim/cpu8_arith_logic_decode_props.sv]
/* Decoder checker on the top ports.
   Assumes one clock and active-low reset. */
`default_nettype none
module cpu8_arith_logic_decode_props
   import alu_decode_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic opcode_valid_i,
   input wire logic [7:0] opcode_i,
   input wire logic decoded_o,
   input wire logic hit_o,
   input wire alu_op_e op_o,
   input wire operand_src_e src_o,
   input wire logic [2:0] src_reg_field_o,
   input wire logic [1:0] pair_o,
   input wire logic [4:0] cycles_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   logic seen_r;
   logic live_r;
   logic v;
   logic [7:0] o;
   // Mirrors the decoder's two-flop release: earlier strobes are dropped
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seen_r <= 1'b0;
         live_r <= 1'b0;
      end else begin
         seen_r <= 1'b1;
         live_r <= seen_r;
      end
   end
   assign v = opcode_valid_i && live_r;
   assign o = opcode_i;
   property p_mem;
      v && o[7:6] == 2'b10 && o[2:0] == 3'h6 |=> src_o == src_mem && cycles_o == CYC_MEM
         && src_reg_field_o == REG_MEM;
   endproperty
   a_mem: assert property (p_mem) else $error("memory operand decode");
   property p_imm;
      v && o[7:6] == 2'b11 && o[2:0] == 3'h6 |=> src_o == src_imm && cycles_o == CYC_MEM;
   endproperty
   a_imm: assert property (p_imm) else $error("immediate decode");
   property p_pair;
      v && o[7:6] == 2'b00 && o[3:0] == 4'h9 |=> op_o == op_pair_add
         && pair_o == $past(o[5:4]) && cycles_o == CYC_PAIR;
   endproperty
   a_pair: assert property (p_pair) else $error("pair add decode");
   property p_sub;
      v && o[7:4] == 4'h9 && o[2:0] != 3'h6 |=> cycles_o == CYC_REG
         && op_o == ($past(o[3]) ? op_sub_borrow : op_sub);
   endproperty
   a_sub: assert property (p_sub) else $error("register subtract");
   property p_logic;
      v && o[7:5] == 3'b101 && o[2:0] != 3'h6 |=> src_o == src_reg
         && src_reg_field_o == $past(o[2:0]) && cycles_o == CYC_REG;
   endproperty
   a_logic: assert property (p_logic) else $error("register logic");
   property p_acc;
      v && o[7:6] == 2'b00 && o[2:0] == 3'h7 |=> hit_o && cycles_o == CYC_REG;
   endproperty
   a_acc: assert property (p_acc) else $error("rotate or special");
   property p_stop;
      v && o == OPC_STOP |=> (op_o == op_stop && cycles_o == CYC_STOP)
         ##1 (decoded_o == $past(opcode_valid_i));
   endproperty
   a_stop: assert property (p_stop) else $error("halt decode");
   property p_cond;
      v && o[7:6] == 2'b11 && o[2:0] == 3'h0 |=> !hit_o && op_o == op_none && cycles_o == 5'h00;
   endproperty
   a_cond: assert property (p_cond) else $error("conditional count leak");
   property p_settle;
      !live_r |=> !decoded_o && !hit_o && op_o == op_none && cycles_o == CYC_NONE;
   endproperty
   a_settle: assert property (p_settle) else $error("output active before release settled");
   property p_pulse;
      live_r |=> decoded_o == $past(opcode_valid_i);
   endproperty
   a_pulse: assert property (p_pulse) else $error("decoded pulse mismatch");
   property p_hold;
      live_r && !opcode_valid_i |=> $stable(op_o) && $stable(src_o) && $stable(cycles_o)
         && $stable(hit_o);
   endproperty
   a_hold: assert property (p_hold) else $error("fields changed without strobe");
   c_mem: cover property (v && o == OPC_ADD_MEM);
   c_miss: cover property (v && o == 8'hc0);
   c_pair: cover property (v && o == 8'h39);
   c_b2b: cover property (v ##1 v);
endmodule
bind cpu8_arith_logic_decode cpu8_arith_logic_decode_props u_props (.clk_sys_i(clk_sys_i),
   .rstn_i(rstn_i), .opcode_valid_i(opcode_valid_i), .opcode_i(opcode_i), .decoded_o(decoded_o),
   .hit_o(hit_o), .op_o(op_o), .src_o(src_o), .src_reg_field_o(src_reg_field_o),
   .pair_o(pair_o), .cycles_o(cycles_o));
`default_nettype wire

// [sim/cpu8_arith_logic_decode_tb_top.sv]
/* Table-driven decoder bench, opcodes fetched from the memory model.
   Assumes package, model and checker compiled first. */
`default_nettype none
module cpu8_arith_logic_decode_tb_top
   import alu_decode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] opc; alu_op_e op; operand_src_e src; logic [4:0] cyc;} row_s;
   localparam int N = 46;
   row_s rows [N] = '{'{8'h86, op_add, src_mem, CYC_MEM},
      '{8'h8e, op_add_carry, src_mem, CYC_MEM}, '{8'h87, op_add, src_reg, CYC_REG},
      '{8'h89, op_add_carry, src_reg, CYC_REG}, '{8'hc6, op_add, src_imm, CYC_MEM},
      '{8'hce, op_add_carry, src_imm, CYC_MEM}, '{8'h09, op_pair_add, src_none, CYC_PAIR},
      '{8'h19, op_pair_add, src_none, CYC_PAIR}, '{8'h29, op_pair_add, src_none, CYC_PAIR},
      '{8'h39, op_pair_add, src_none, CYC_PAIR}, '{8'h90, op_sub, src_reg, CYC_REG},
      '{8'h9f, op_sub_borrow, src_reg, CYC_REG}, '{8'h98, op_sub_borrow, src_reg, CYC_REG},
      '{8'h96, op_sub, src_mem, CYC_MEM}, '{8'h9e, op_sub_borrow, src_mem, CYC_MEM},
      '{8'hd6, op_sub, src_imm, CYC_MEM}, '{8'hde, op_sub_borrow, src_imm, CYC_MEM},
      '{8'ha0, op_and, src_reg, CYC_REG}, '{8'ha8, op_xor, src_reg, CYC_REG},
      '{8'hb3, op_or, src_reg, CYC_REG}, '{8'hbf, op_compare, src_reg, CYC_REG},
      '{8'ha6, op_and, src_mem, CYC_MEM}, '{8'hae, op_xor, src_mem, CYC_MEM},
      '{8'hb6, op_or, src_mem, CYC_MEM}, '{8'hbe, op_compare, src_mem, CYC_MEM},
      '{8'he6, op_and, src_imm, CYC_MEM}, '{8'hee, op_xor, src_imm, CYC_MEM},
      '{8'hf6, op_or, src_imm, CYC_MEM}, '{8'hfe, op_compare, src_imm, CYC_MEM},
      '{8'h07, op_rotate_left, src_none, CYC_REG}, '{8'h0f, op_rotate_right, src_none, CYC_REG},
      '{8'h17, op_rotate_left_thru_carry, src_none, CYC_REG},
      '{8'h1f, op_rotate_right_thru_carry, src_none, CYC_REG},
      '{8'h2f, op_acc_invert, src_none, CYC_REG}, '{8'h37, op_carry_set, src_none, CYC_REG},
      '{8'h3f, op_carry_invert, src_none, CYC_REG},
      '{8'h27, op_decimal_adjust, src_none, CYC_REG},
      '{8'hfb, op_irq_enable, src_none, CYC_REG}, '{8'hf3, op_irq_disable, src_none, CYC_REG},
      '{8'h00, op_no_operation, src_none, CYC_REG}, '{8'h20, op_mask_read, src_none, CYC_REG},
      '{8'h30, op_mask_write, src_none, CYC_REG}, '{8'hc0, op_none, src_none, CYC_NONE},
      '{8'hc9, op_none, src_none, CYC_NONE}, '{8'h04, op_none, src_none, CYC_NONE},
      '{8'h76, op_stop, src_none, CYC_STOP}};
   logic clk_sys_i, rstn_i, valid, sel, decoded, hit;
   logic [5:0] addr;
   logic [7:0] code;
   alu_op_e op;
   operand_src_e src;
   logic [2:0] field;
   logic [1:0] pair;
   logic [4:0] cyc;
   int miscompares = 0;
   int total_checks = 0;
   int ticks = 0;
   opcode_mem_model MEM (.sel_i(sel), .addr_i(addr), .data_o(code));
   cpu8_arith_logic_decode DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .opcode_valid_i(valid),
      .opcode_i(code), .decoded_o(decoded), .hit_o(hit), .op_o(op), .src_o(src),
      .src_reg_field_o(field), .pair_o(pair), .cycles_o(cyc));
   task automatic test_done();
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic row(input row_s r);
      chk("decoded", 8'h01, decoded);
      chk("hit", r.op != op_none, hit);
      chk("op", r.op, op);
      chk("src", r.src, src);
      chk("cycles", r.cyc, cyc);
      chk("field", r.opc[2:0], field);
      if (r.op == op_pair_add) chk("pair", r.opc[5:4], pair);
   endtask
   initial begin
      clk_sys_i = 0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      ticks++;
      if (ticks == 1000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      rstn_i = 0;
      valid = 0;
      sel = 0;
      addr = 6'h00;
      foreach (rows[i]) MEM.mem_r[i] = rows[i].opc;
      repeat (6) @(negedge clk_sys_i);
      rstn_i = 1;
      repeat (2) @(negedge clk_sys_i);
      chk("idle_cycles", 8'h00, cyc);
      sel = 1;
      valid = 1;
      for (int i = 0; i < N; i++) begin
         addr = 6'(i);
         @(negedge clk_sys_i);
         row(rows[i]);
      end
      valid = 0;
      sel = 0;
      @(negedge clk_sys_i);
      chk("pulse", 8'h00, decoded);
      chk("held", CYC_STOP, cyc);
      chk("held_hit", 8'h01, hit);
      rstn_i = 0;
      #1;
      chk("reset_op", op_none, op);
      chk("reset_hit", 8'h00, hit);
      chk("reset_cycles", CYC_NONE, cyc);
      // Strobe held across the release: the first two edges must drop it
      @(negedge clk_sys_i);
      addr = 6'h00;
      sel = 1;
      valid = 1;
      rstn_i = 1;
      repeat (2) begin
         @(negedge clk_sys_i);
         chk("early_drop", 8'h00, decoded);
      end
      @(negedge clk_sys_i);
      row(rows[0]);
      valid = 0;
      sel = 0;
      test_done();
   end
endmodule
`default_nettype wire

// [sim/opcode_mem_model.sv]
/* Opcode memory model: returns stored bytes by index.
   Assumes the bench loads mem_r and selects it only while fetching. */
`default_nettype none
module opcode_mem_model (
   input wire logic sel_i,
   input wire logic [5:0] addr_i,
   output logic [7:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_r [64];
   logic [7:0] last_r = 8'h00;
   // Released bus shows the inverse of the last byte, never a stale copy
   always_comb data_o = sel_i ? mem_r[addr_i] : ~last_r;
   always @(negedge sel_i) last_r = mem_r[addr_i];
endmodule
`default_nettype wire
